/* File: design/clock_ctrl_map.svh */
`ifndef CLOCK_CTRL_MAP_SVH
`define CLOCK_CTRL_MAP_SVH

// register indices; byte address is four times the index
`define IDX_SLOW_OSC_TRIM 8'h3C
`define IDX_PLL_CTRL 8'h3D
`define IDX_OUT_DIV 8'h3E
`define IDX_PIN_STATUS 8'h20
`define BYTE_ADDR_LSB 2

// reset values
`define RST_SLOW_OSC_TRIM 8'h00
`define RST_PLL_CTRL 8'h00
`define RST_OUT_DIV 8'h00

// source selector codes
`define SRC_GPIO 4'h0
`define SRC_PLL 4'h1
`define SRC_LOW 4'h2
`define SRC_HIGH 4'h3
`define SRC_XTAL_DIV1 4'h4
`define SRC_XTAL_DIV2 4'h5
`define SRC_XTAL_DIV4 4'h6
`define SRC_XTAL_DIV8 4'h7
`define SRC_TIMER_ZERO_OVERFLOW 4'h8
`define SRC_TIMER1 4'h9
`define SRC_TIMER2 4'hA
`define SRC_TIMER3 4'hB

// feedback factors
`define FB_SEL_23 2'h0
`define FB_SEL_27 2'h1
`define FB_SEL_28 2'h2
`define FB_FACTOR_23 5'h17
`define FB_FACTOR_27 5'h1B
`define FB_FACTOR_28 5'h1C

// output divider legal range
`define OUT_DIV_MIN 8'h08
`define OUT_DIV_MAX 8'hFE

// avalon response codes
`define AVS_RESP_OKAY 2'h0
`define AVS_RESP_SLVERR 2'h2

`endif

/* File: design/clock_ctrl_pkg.sv */
package clock_ctrl_pkg;

	typedef struct packed {
		logic [3:0] pin_clock_source_select;
		logic pin_clock_drive_enable;
		logic synth_power_down;
		logic [1:0] feedback_divide_select;
	} pll_ctrl_t;

	typedef struct packed {
		logic [4:0] unused;
		logic pin_drive;
		logic divider_valid;
		logic pin_level;
	} pin_status_t;

	typedef struct packed {
		logic xtal;
		logic pll_stage1;
		logic pin;
	} pin_inputs_t;

endpackage

/* File: design/sync2.sv */
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// data
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule // sync2

`default_nettype wire

/* File: design/edge_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module edge_divider #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// control
	input wire logic run_i,
	input wire logic [W-1:0] factor_i,
	// signal
	input wire logic sig_i,
	output logic div_o
);

	logic prev_q;
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic rise;

	assign rise = sig_i & ~prev_q;

	// counts input rising edges modulo factor; high for the first half
	always_comb begin
		cnt_d = cnt_q;
		if (rise) begin
			if (cnt_q >= factor_i - {{(W-1){1'b0}}, 1'b1})
				cnt_d = '0;
			else
				cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			prev_q <= 1'b0;
		else
			prev_q <= sig_i;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !run_i) begin
			cnt_q <= '0;
			div_o <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			div_o <= (cnt_d < (factor_i >> 1));
		end
	end

endmodule // edge_divider

`default_nettype wire

/* File: design/clock_pin_ctrl.sv */
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "clock_ctrl_map.svh"

module clock_pin_ctrl (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// avalon-mm slave
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	// clock sources
	input wire logic xtal_clk_i,
	input wire logic pll_stage1_clk_i,
	input wire logic [3:0] timer_overflow_i,
	// plain i/o path
	input wire logic gpio_out_i,
	input wire logic gpio_oe_i,
	output logic gpio_in_o,
	// clock output pin
	input wire logic clock_output_pin_i,
	output logic clock_output_pin_o,
	output logic clock_output_pin_oe_o,
	// analog controls
	output logic [7:0] slow_osc_trim_value_o,
	output logic synth_power_down_o,
	output logic [4:0] feedback_divide_factor_o,
	output logic [7:0] output_divide_factor_o
);

	logic [7:0] trim_q;
	clock_ctrl_pkg::pll_ctrl_t ctrl_q;
	logic [7:0] out_div_q;
	clock_ctrl_pkg::pin_inputs_t raw_in;
	clock_ctrl_pkg::pin_inputs_t sync_in;
	clock_ctrl_pkg::pin_status_t status;

	logic [7:0] word_index;
	logic bus_req;
	logic do_write;
	logic mapped;
	logic [7:0] read_byte;
	logic wr_trim;
	logic wr_ctrl;
	logic wr_div;

	logic xtal_prev_q;
	logic [2:0] xtal_cnt_q;
	logic div_valid;
	logic pll_run;
	logic pll_clk;
	logic [3:0] timer_tgl_q;
	logic pin_d;
	logic oe_d;

	// decode helpers
	function automatic logic [4:0] fb_factor(input logic [1:0] sel);
		case (sel)
			`FB_SEL_23: fb_factor = `FB_FACTOR_23;
			`FB_SEL_27: fb_factor = `FB_FACTOR_27;
			`FB_SEL_28: fb_factor = `FB_FACTOR_28;
			default: fb_factor = `FB_FACTOR_23;
		endcase
	endfunction

	function automatic logic is_mapped(input logic [7:0] idx);
		case (idx)
			`IDX_SLOW_OSC_TRIM,
			`IDX_PLL_CTRL,
			`IDX_OUT_DIV,
			`IDX_PIN_STATUS: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// bus slave
	assign word_index = avs_address_i[9:`BYTE_ADDR_LSB];
	assign bus_req = avs_read_i | avs_write_i;
	assign mapped = is_mapped(word_index);
	// a write lands at the edge the master sees waitrequest low
	assign do_write = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
	// one strobe per writable register, decoded once
	assign wr_trim = do_write & (word_index == `IDX_SLOW_OSC_TRIM);
	assign wr_ctrl = do_write & (word_index == `IDX_PLL_CTRL);
	assign wr_div = do_write & (word_index == `IDX_OUT_DIV);

	// one wait cycle, then a one-cycle acknowledge
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			avs_waitrequest_o <= 1'b1;
		else if (bus_req && avs_waitrequest_o)
			avs_waitrequest_o <= 1'b0;
		else
			avs_waitrequest_o <= 1'b1;
	end

	// reads see the registers as stored, reserved divider values included
	always_comb begin
		read_byte = 8'h00;
		case (word_index)
			`IDX_SLOW_OSC_TRIM: read_byte = trim_q;
			`IDX_PLL_CTRL: read_byte = ctrl_q;
			`IDX_OUT_DIV: read_byte = out_div_q;
			`IDX_PIN_STATUS: read_byte = status;
			default: read_byte = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			avs_readdata_o <= 32'h00000000;
		else if (bus_req && avs_waitrequest_o)
			avs_readdata_o <= {24'h000000, read_byte};
	end

	// unmapped indices answer with an error, not a silent zero
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			avs_response_o <= `AVS_RESP_OKAY;
		else if (bus_req && avs_waitrequest_o)
			avs_response_o <= mapped ? `AVS_RESP_OKAY : `AVS_RESP_SLVERR;
	end

	// configuration registers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			trim_q <= `RST_SLOW_OSC_TRIM;
		else if (wr_trim)
			trim_q <= avs_writedata_i[7:0];
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			ctrl_q <= `RST_PLL_CTRL;
		else if (wr_ctrl)
			ctrl_q <= avs_writedata_i[7:0];
	end

	// reserved divider values are stored but never run the divider
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			out_div_q <= `RST_OUT_DIV;
		else if (wr_div)
			out_div_q <= avs_writedata_i[7:0];
	end

	// analog control outputs
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			slow_osc_trim_value_o <= `RST_SLOW_OSC_TRIM;
		else
			// larger trim lowers the oscillator frequency in the analog cell
			slow_osc_trim_value_o <= trim_q;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			synth_power_down_o <= 1'b0;
		else
			synth_power_down_o <= ctrl_q.synth_power_down;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			feedback_divide_factor_o <= `FB_FACTOR_23;
		else
			// the analog loop multiplies the crystal by this and halves it
			feedback_divide_factor_o <= fb_factor(ctrl_q.feedback_divide_select);
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			output_divide_factor_o <= `RST_OUT_DIV;
		else
			output_divide_factor_o <= out_div_q;
	end

	// pin inputs
	assign raw_in.xtal = xtal_clk_i;
	assign raw_in.pll_stage1 = pll_stage1_clk_i;
	assign raw_in.pin = clock_output_pin_i;

	sync2 #(
		.W(3)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.async_i(raw_in),
		.sync_o(sync_in)
	);

	// crystal dividers; sampled edges limit fidelity to the system rate
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			xtal_prev_q <= 1'b0;
		else
			xtal_prev_q <= sync_in.xtal;
	end

	// a free-running count of edges gives /2, /4 and /8 from its bits
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			xtal_cnt_q <= 3'h0;
		else if (sync_in.xtal && !xtal_prev_q)
			xtal_cnt_q <= xtal_cnt_q + 3'h1;
	end

	// second synthesiser stage
	assign div_valid = (out_div_q >= `OUT_DIV_MIN) && (out_div_q <= `OUT_DIV_MAX);
	assign pll_run = div_valid & ~ctrl_q.synth_power_down;

	// a stopped divider rests low, so the pin shows no runt pulse
	edge_divider #(
		.W(8)
	) u_out_div (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.run_i(pll_run),
		.factor_i(out_div_q),
		.sig_i(sync_in.pll_stage1),
		.div_o(pll_clk)
	);

	// timer overflow toggles, restarted when not selected
	// a pulse that arrives while its code is not selected is dropped
	genvar t;
	generate
		for (t = 0; t < 4; t++) begin : g_timer_tgl
			always_ff @(posedge sys_clk_i) begin
				if (rst_i)
					timer_tgl_q[t] <= 1'b0;
				else if (ctrl_q.pin_clock_source_select != (`SRC_TIMER_ZERO_OVERFLOW + 4'(t)))
					timer_tgl_q[t] <= 1'b0;
				else if (timer_overflow_i[t])
					timer_tgl_q[t] <= ~timer_tgl_q[t];
			end
		end
	endgenerate

	// output multiplexer
	always_comb begin
		pin_d = 1'b0;
		oe_d = ctrl_q.pin_clock_drive_enable;
		case (ctrl_q.pin_clock_source_select)
			// plain i/o ignores the enable bit
			`SRC_GPIO: begin
				pin_d = gpio_out_i;
				oe_d = gpio_oe_i;
			end
			`SRC_PLL: pin_d = pll_clk;
			`SRC_LOW: pin_d = 1'b0;
			`SRC_HIGH: pin_d = 1'b1;
			`SRC_XTAL_DIV1: pin_d = sync_in.xtal;
			`SRC_XTAL_DIV2: pin_d = xtal_cnt_q[0];
			`SRC_XTAL_DIV4: pin_d = xtal_cnt_q[1];
			`SRC_XTAL_DIV8: pin_d = xtal_cnt_q[2];
			`SRC_TIMER_ZERO_OVERFLOW: pin_d = timer_tgl_q[0];
			`SRC_TIMER1: pin_d = timer_tgl_q[1];
			`SRC_TIMER2: pin_d = timer_tgl_q[2];
			`SRC_TIMER3: pin_d = timer_tgl_q[3];
			// reserved codes drive a quiet low
			default: pin_d = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			clock_output_pin_o <= 1'b0;
		else
			clock_output_pin_o <= pin_d;
	end

	// drive stays off through reset so the pin never glitches
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			clock_output_pin_oe_o <= 1'b0;
		else
			clock_output_pin_oe_o <= oe_d;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			gpio_in_o <= 1'b0;
		else
			gpio_in_o <= sync_in.pin;
	end

	// status view; read-only, writes to its index are dropped
	assign status.unused = 5'h00;
	assign status.pin_drive = clock_output_pin_oe_o;
	assign status.divider_valid = div_valid;
	assign status.pin_level = sync_in.pin;

endmodule // clock_pin_ctrl

`default_nettype wire

/* File: tb/clock_pin_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "clock_ctrl_map.svh"

module clock_pin_ctrl_asserts (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// bus
	input wire logic [9:0] avs_address_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic avs_waitrequest_o,
	// pin and controls
	input wire logic gpio_oe_i,
	input wire logic clock_output_pin_o,
	input wire logic clock_output_pin_oe_o,
	input wire logic [7:0] slow_osc_trim_value_o,
	input wire logic synth_power_down_o,
	input wire logic [4:0] feedback_divide_factor_o,
	input wire logic [7:0] output_divide_factor_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	logic wr;
	logic ctl;
	logic [7:0] d;
	// a write lands only at the edge where waitrequest is low
	assign wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	assign ctl = wr && avs_address_i[9:2] == `IDX_PLL_CTRL;
	assign d = avs_writedata_i[7:0];
	a_trim_follows: assert property (wr && avs_address_i[9:2] == `IDX_SLOW_OSC_TRIM
		|=> ##1 slow_osc_trim_value_o == $past(d, 2)) else $error("trim output wrong");
	a_div_follows: assert property (wr && avs_address_i[9:2] == `IDX_OUT_DIV
		|=> ##1 output_divide_factor_o == $past(d, 2)) else $error("divider output wrong");
	a_pd_follows: assert property (ctl
		|=> ##1 synth_power_down_o == $past(avs_writedata_i[2], 2)) else $error("power down wrong");
	a_pin_low: assert property (ctl && d[7:3] == 5'h05
		|=> ##1 !clock_output_pin_o && clock_output_pin_oe_o) else $error("pin not low");
	a_pin_high: assert property (ctl && d[7:3] == 5'h07
		|=> ##1 clock_output_pin_o && clock_output_pin_oe_o) else $error("pin not high");
	a_gpio_release: assert property (ctl && d[7:4] == 4'h0
		|=> ##1 clock_output_pin_oe_o == $past(gpio_oe_i)) else $error("pin not released");
	a_enable_off: assert property (ctl && d[7:4] != 4'h0 && !d[3]
		|=> ##1 !clock_output_pin_oe_o [*3]) else $error("pin driven while disabled");
	a_fb_legal: assert property (feedback_divide_factor_o inside {5'h17, 5'h1B, 5'h1C})
		else $error("feedback factor illegal");
	a_reset_clear: assert property ($fell(rst_i) |-> slow_osc_trim_value_o == 8'h00
		&& output_divide_factor_o == 8'h00 && feedback_divide_factor_o == 5'h17) else $error("reset state wrong");
endmodule // clock_pin_ctrl_asserts

bind clock_pin_ctrl clock_pin_ctrl_asserts u_chk (
	.sys_clk_i(sys_clk_i),
	.rst_i(rst_i),
	.avs_address_i(avs_address_i),
	.avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i),
	.avs_waitrequest_o(avs_waitrequest_o),
	.gpio_oe_i(gpio_oe_i),
	.clock_output_pin_o(clock_output_pin_o),
	.clock_output_pin_oe_o(clock_output_pin_oe_o),
	.slow_osc_trim_value_o(slow_osc_trim_value_o),
	.synth_power_down_o(synth_power_down_o),
	.feedback_divide_factor_o(feedback_divide_factor_o),
	.output_divide_factor_o(output_divide_factor_o)
);

`default_nettype wire

/* File: tb/clock_pin_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "clock_ctrl_map.svh"

module clock_pin_ctrl_tb_top;
	logic sys_clk_i = 1'h0, rst_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
	logic [9:0] avs_address_i = 10'h0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [3:0] timer_overflow_i = 4'h0;
	logic xtal_clk_i = 1'h0, pll_stage1_clk_i = 1'h0, gpio_out_i = 1'h0, gpio_oe_i = 1'h0;
	logic clock_output_pin_i = 1'h0;
	logic [7:0] ph = 8'h0;
	logic [31:0] rdata;
	logic [1:0] resp;
	wire logic [31:0] avs_readdata_o;
	wire logic [1:0] avs_response_o;
	wire logic [7:0] slow_osc_trim_value_o, output_divide_factor_o;
	wire logic [4:0] feedback_divide_factor_o;
	wire logic avs_waitrequest_o, gpio_in_o, clock_output_pin_o, clock_output_pin_oe_o, synth_power_down_o;
	int n_fail = 0;
	int checked = 0;

	clock_pin_ctrl dut (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.avs_response_o(avs_response_o),
		.xtal_clk_i(xtal_clk_i),
		.pll_stage1_clk_i(pll_stage1_clk_i),
		.timer_overflow_i(timer_overflow_i),
		.gpio_out_i(gpio_out_i),
		.gpio_oe_i(gpio_oe_i),
		.gpio_in_o(gpio_in_o),
		.clock_output_pin_i(clock_output_pin_i),
		.clock_output_pin_o(clock_output_pin_o),
		.clock_output_pin_oe_o(clock_output_pin_oe_o),
		.slow_osc_trim_value_o(slow_osc_trim_value_o),
		.synth_power_down_o(synth_power_down_o),
		.feedback_divide_factor_o(feedback_divide_factor_o),
		.output_divide_factor_o(output_divide_factor_o)
	);

	initial forever #5 sys_clk_i = ~sys_clk_i;
	// slow sources: the block samples them at 100 MHz, so fast ones would alias
	always @(posedge sys_clk_i) begin
		ph <= ph + 8'h01;
		xtal_clk_i <= ph[2];
		pll_stage1_clk_i <= ph[2];
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// waits as long as the slave asks; only the watchdog ends a hang
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge sys_clk_i);
		avs_address_i <= {idx, 2'h0};
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= {24'h0, d};
		do begin
			@(posedge sys_clk_i);
		end while (avs_waitrequest_o !== 1'h0);
		rdata = avs_readdata_o;
		resp = avs_response_o;
		avs_write_i <= 1'h0;
		avs_read_i <= 1'h0;
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
		bus(1'h0, idx, 8'h00);
		chk(rdata, e);
	endtask

	task automatic pin(input logic [7:0] c, input logic [1:0] e);
		bus(1'h1, `IDX_PLL_CTRL, c);
		repeat (3) @(posedge sys_clk_i);
		chk({clock_output_pin_oe_o, clock_output_pin_o}, e);
	endtask

	task automatic pulse(input logic [3:0] m, input logic e);
		@(posedge sys_clk_i);
		timer_overflow_i <= m;
		@(posedge sys_clk_i);
		timer_overflow_i <= 4'h0;
		repeat (3) @(posedge sys_clk_i);
		chk(clock_output_pin_o, e);
	endtask

	// rising edges over 256 cycles, one edge of slack for phase
	task automatic cnt(input logic [7:0] c, input int e);
		int n;
		logic p;
		n = 0;
		bus(1'h1, `IDX_PLL_CTRL, c);
		repeat (4) @(posedge sys_clk_i);
		p = clock_output_pin_o;
		repeat (256) begin
			@(posedge sys_clk_i);
			if (clock_output_pin_o && !p) n++;
			p = clock_output_pin_o;
		end
		chk(32'(n >= e - 1 && n <= e + 1), 32'h1);
	endtask

	task automatic t_reset;
		rchk(`IDX_SLOW_OSC_TRIM, 32'h0);
		rchk(`IDX_PLL_CTRL, 32'h0);
		rchk(`IDX_OUT_DIV, 32'h0);
		chk(feedback_divide_factor_o, 32'h17);
		$display("test reset done");
	endtask

	task automatic t_regs;
		logic [4:0] f [4] = '{5'h17, 5'h1B, 5'h1C, 5'h17};
		for (int i = 0; i < 4; i++) begin
			bus(1'h1, `IDX_PLL_CTRL, 8'(i) | 8'h04);
			repeat (2) @(posedge sys_clk_i);
			chk({synth_power_down_o, feedback_divide_factor_o}, {1'h1, f[i]});
		end
		bus(1'h1, `IDX_SLOW_OSC_TRIM, 8'hFF);
		bus(1'h1, `IDX_OUT_DIV, 8'hFE);
		rchk(`IDX_SLOW_OSC_TRIM, 32'hFF);
		rchk(`IDX_OUT_DIV, 32'hFE);
		avs_byteenable_i <= 4'hE;
		bus(1'h1, `IDX_SLOW_OSC_TRIM, 8'h00);
		avs_byteenable_i <= 4'hF;
		rchk(`IDX_SLOW_OSC_TRIM, 32'hFF);
		chk({slow_osc_trim_value_o, output_divide_factor_o}, 32'hFFFE);
		rchk(8'h3F, 32'h0);
		chk(resp, `AVS_RESP_SLVERR);
		$display("test registers done");
	endtask

	task automatic t_pin;
		gpio_out_i <= 1'h1;
		gpio_oe_i <= 1'h1;
		clock_output_pin_i <= 1'h1;
		pin(8'h00, 2'h3);
		chk(gpio_in_o, 32'h1);
		rchk(`IDX_PIN_STATUS, 32'h7);
		pin(8'h28, 2'h2);
		pin(8'h38, 2'h3);
		// released pin: drive off, level still follows the selector
		pin(8'h30, 2'h1);
		pin(8'hC8, 2'h2);
		for (int k = 0; k < 4; k++) begin
			pin(8'h88 + 8'(k << 4), 2'h2);
			pulse(4'(1 << k), 1'h1);
			pulse(~4'(1 << k), 1'h1);
			pulse(4'(1 << k), 1'h0);
		end
		$display("test pin done");
	endtask

	task automatic t_clk;
		bus(1'h1, `IDX_OUT_DIV, 8'h08);
		cnt(8'h18, 4);
		for (int s = 4; s < 8; s++) cnt(8'(s << 4) | 8'h08, 32 >> (s - 4));
		cnt(8'h1C, 0);
		$display("test clocks done");
	endtask

	task automatic results;
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge sys_clk_i);
		rst_i <= 1'h0;
		t_reset();
		t_regs();
		t_pin();
		t_clk();
		results();
	end

	initial begin
		#100us;
		n_fail++;
		results();
	end
endmodule // clock_pin_ctrl_tb_top

`default_nettype wire
